// [verilog/cpc_config_port.sv]
`timescale 1ns/1ps
module cpc_config_port
   import cpc_pkg::*;
(
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst,
   // Configuration restart request from the device core
   input  wire logic              clear_req,
   // Mode and option pins
   input  wire logic [MODE_W-1:0] mode_select_pins,
   input  wire logic              port_retain,
   // Parallel port control pins
   input  wire logic              port_sel_n,
   input  wire logic              read_write_sel,
   input  wire logic              xfer_strobe,
   input  wire logic [BYTE_W-1:0] cfg_data_pins,
   // Serial data input pin
   input  wire logic              serial_din,
   // Busy / serial-out shared pin
   output logic                   busy_dout_out,
   output logic                   busy_dout_oe,
   // Init/error open-drain pin
   input  wire logic              init_err_in,
   output logic                   init_err_out,
   output logic                   init_err_oe,
   // Byte stream to configuration core
   output logic                   cfg_byte_valid,
   input  wire logic              cfg_byte_ready,
   output logic [BYTE_W-1:0]      cfg_byte_data,
   // Core feedback
   input  wire logic              cfg_error,
   input  wire logic              cfg_finished,
   // Status
   output logic                   config_done,
   output logic                   port_pins_active,
   output logic                   read_refused
);
   // Two-flop synchronisers for every pin input except port_retain, which is used unsynchronised
   logic [1:0]        sel_n_sync_reg;
   logic [1:0]        rw_sync_reg;
   logic [1:0]        strb_sync_reg;
   logic [1:0]        din_sync_reg;
   logic [1:0]        init_sync_reg;
   logic [MODE_W-1:0] mode_s1_reg;
   logic [MODE_W-1:0] mode_s2_reg;
   logic [BYTE_W-1:0] data_s1_reg;
   logic [BYTE_W-1:0] data_s2_reg;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         sel_n_sync_reg <= 2'h3;
         rw_sync_reg    <= 2'h3;
         strb_sync_reg  <= 2'h0;
         din_sync_reg   <= 2'h0;
         init_sync_reg  <= 2'h3;
         mode_s1_reg    <= '0;
         mode_s2_reg    <= '0;
         data_s1_reg    <= '0;
         data_s2_reg    <= '0;
      end
      else
      begin
         sel_n_sync_reg <= {sel_n_sync_reg[0], port_sel_n};
         rw_sync_reg    <= {rw_sync_reg[0], read_write_sel};
         strb_sync_reg  <= {strb_sync_reg[0], xfer_strobe};
         din_sync_reg   <= {din_sync_reg[0], serial_din};
         init_sync_reg  <= {init_sync_reg[0], init_err_in};
         mode_s1_reg    <= mode_select_pins;
         mode_s2_reg    <= mode_s1_reg;
         data_s1_reg    <= cfg_data_pins;
         data_s2_reg    <= data_s1_reg;
      end
   end

   logic strb_prev_reg;
   logic strb_rise;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         strb_prev_reg <= 1'b0;
      else
         strb_prev_reg <= strb_sync_reg[1];
   end

   assign strb_rise = strb_sync_reg[1] & ~strb_prev_reg;

   // Sequencer
   cpc_state_e            state_reg;
   cpc_state_e            state_next;
   logic [CLR_CNT_W-1:0]  clr_cnt_reg;
   logic                  clr_over;
   logic [MODE_W-1:0]     mode_reg;
   logic                  err_reg;

   assign clr_over = (clr_cnt_reg == CLR_CNT_W'(CLEAR_CYCLES - 1));

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         CPC_CLEAR:
            if (clr_over)
               state_next = CPC_HOLD;
         CPC_HOLD:
            if (init_sync_reg[1])
               state_next = CPC_LOAD;
         CPC_LOAD:
            if (cfg_finished & ~err_reg)
               state_next = CPC_DONE;
         CPC_DONE:
            state_next = CPC_DONE;
         default:
            state_next = CPC_CLEAR;
      endcase
      if (clear_req)
         state_next = CPC_CLEAR;
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         state_reg <= CPC_CLEAR;
      else
         state_reg <= state_next;
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         clr_cnt_reg <= '0;
      else if (state_reg != CPC_CLEAR || clear_req)
         clr_cnt_reg <= '0;
      else if (!clr_over)
         clr_cnt_reg <= clr_cnt_reg + CLR_CNT_W'(1);
   end

   // Mode is caught when clearing ends so a late strap change mid-load is ignored
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         mode_reg <= MODE_SCAN;
      else if (state_reg == CPC_CLEAR && clr_over)
         mode_reg <= mode_s2_reg;
   end

   // Error flag holds until the next memory clear; the core's report wins
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         err_reg <= 1'b0;
      else if (state_reg == CPC_LOAD && cfg_error)
         err_reg <= 1'b1;
      else if (state_reg == CPC_CLEAR)
         err_reg <= 1'b0;
   end

   logic mode_par;
   logic mode_ser;
   logic loading;
   logic port_on;

   assign mode_par = (mode_reg == MODE_PAR_MASTER) || (mode_reg == MODE_PAR_SLAVE);
   assign mode_ser = (mode_reg == MODE_SER_MASTER) || (mode_reg == MODE_SER_SLAVE);
   assign loading  = (state_reg == CPC_LOAD) & ~err_reg;
   assign port_on  = mode_par & (loading | ((state_reg == CPC_DONE) & port_retain));

   // Byte capture into the buffer
   logic              buf_in_valid;
   logic              buf_in_ready;
   logic [BYTE_W-1:0] buf_in_data;
   logic              sel_active;
   logic              par_take;
   logic              par_read;
   logic [BYTE_W-1:0] ser_shift_reg;
   logic [2:0]        ser_cnt_reg;
   logic              ser_take;

   assign sel_active = ~sel_n_sync_reg[1];
   assign par_take   = port_on & sel_active & strb_rise & (rw_sync_reg[1] == RW_WRITE);
   assign par_read   = port_on & sel_active & strb_rise & (rw_sync_reg[1] == RW_READ);
   assign ser_take   = loading & mode_ser & strb_rise;

   // Readback is not supported; a read strobe is only flagged
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         read_refused <= 1'b0;
      else
         read_refused <= par_read;
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         ser_shift_reg <= '0;
         ser_cnt_reg   <= 3'h0;
      end
      else if (!loading)
         ser_cnt_reg <= 3'h0;
      else if (ser_take)
      begin
         ser_shift_reg <= {ser_shift_reg[BYTE_W-2:0], din_sync_reg[1]};
         ser_cnt_reg   <= ser_cnt_reg + 3'h1;
      end
   end

   logic ser_byte_ready_reg;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         ser_byte_ready_reg <= 1'b0;
      else
         ser_byte_ready_reg <= ser_take & (ser_cnt_reg == 3'h7);
   end

   // A full serial byte arriving while busy is dropped; serial hosts have no throttle
   assign buf_in_valid = par_take | ser_byte_ready_reg;
   assign buf_in_data  = ser_byte_ready_reg ? ser_shift_reg : data_s2_reg;

   cpc_buf2 #(
      .WIDTH (BYTE_W)
   ) cpc_buf2_inst (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .in_valid  (buf_in_valid),
      .in_ready  (buf_in_ready),
      .in_data   (buf_in_data),
      .out_valid (cfg_byte_valid),
      .out_ready (cfg_byte_ready),
      .out_data  (cfg_byte_data)
   );

   // Shared busy / serial-out pin
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         busy_dout_out <= 1'b0;
         busy_dout_oe  <= 1'b0;
      end
      else if (port_on)
      begin
         busy_dout_out <= ~buf_in_ready;
         busy_dout_oe  <= 1'b1;
      end
      else if (mode_ser && loading)
      begin
         busy_dout_out <= din_sync_reg[1];
         busy_dout_oe  <= 1'b1;
      end
      else
      begin
         busy_dout_out <= 1'b0;
         busy_dout_oe  <= 1'b0;
      end
   end

   // Open drain: only ever pulls low, released lets the pull-up win
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         init_err_oe <= 1'b1;
      else
         init_err_oe <= (state_next == CPC_CLEAR) | (err_reg & (state_reg == CPC_LOAD));
   end

   assign init_err_out = 1'b0;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         config_done      <= 1'b0;
         port_pins_active <= 1'b0;
      end
      else
      begin
         config_done      <= (state_next == CPC_DONE);
         port_pins_active <= port_on;
      end
   end
endmodule

// [verilog/cpc_pkg.sv]
package cpc_pkg;
   // Clock and timing
   localparam int unsigned CLK_PERIOD_PS = 5000;
   localparam int unsigned CLEAR_TIME_NS = 1000;
   localparam int unsigned CLEAR_CYCLES  =
      (CLEAR_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned CLR_CNT_W     = $clog2(CLEAR_CYCLES + 1);

   // Data widths
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned MODE_W = 3;

   // Mode select pin encodings
   localparam logic [MODE_W-1:0] MODE_SER_MASTER = 3'h0;
   localparam logic [MODE_W-1:0] MODE_SER_SLAVE  = 3'h7;
   localparam logic [MODE_W-1:0] MODE_PAR_MASTER = 3'h3;
   localparam logic [MODE_W-1:0] MODE_PAR_SLAVE  = 3'h6;
   localparam logic [MODE_W-1:0] MODE_SCAN       = 3'h5;

   // Pin levels
   localparam logic RW_WRITE = 1'b0;
   localparam logic RW_READ  = 1'b1;

   typedef enum logic [3:0] {
      CPC_CLEAR  = 4'h1,
      CPC_HOLD   = 4'h2,
      CPC_LOAD   = 4'h4,
      CPC_DONE   = 4'h8
   } cpc_state_e;
endpackage

// [verilog/cpc_buf2.sv]
`timescale 1ns/1ps
module cpc_buf2
#(
   parameter int unsigned WIDTH = 8
)
(
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   logic [WIDTH-1:0] mem_reg [2];
   logic             wr_ptr_reg;
   logic             rd_ptr_reg;
   logic [1:0]       count_reg;
   logic             push;
   logic             pop;

   assign in_ready  = (count_reg != 2'h2);
   assign out_valid = (count_reg != 2'h0);
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg  <= 2'h0;
      end
      else
      begin
         if (push)
            wr_ptr_reg <= ~wr_ptr_reg;
         if (pop)
            rd_ptr_reg <= ~rd_ptr_reg;
         if (push & ~pop)
            count_reg <= count_reg + 2'h1;
         else if (pop & ~push)
            count_reg <= count_reg - 2'h1;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (push)
         mem_reg[wr_ptr_reg] <= in_data;
   end

   // Storage is flopped, so the head word is a register output
   assign out_data = mem_reg[rd_ptr_reg];
endmodule

// [sim/cpc_config_port_properties.sv]
`timescale 1ns/1ps
module cpc_config_port_properties
   import cpc_pkg::*;
(
   // Clock and reset
   input wire logic              sys_clk,
   input wire logic              rst,
   // Watched inputs
   input wire logic              clear_req,
   input wire logic              port_retain,
   input wire logic              port_sel_n,
   input wire logic              read_write_sel,
   input wire logic [MODE_W-1:0] mode_select_pins,
   input wire logic              serial_din,
   input wire logic              cfg_error,
   // Watched outputs
   input wire logic              busy_dout_out,
   input wire logic              busy_dout_oe,
   input wire logic              init_err_oe,
   input wire logic              cfg_byte_valid,
   input wire logic              config_done,
   input wire logic              port_pins_active,
   input wire logic              read_refused
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   // Long dwell in scan mode, so the captured mode must be scan too
   logic [8:0] scan_cnt;
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         scan_cnt <= 9'h000;
      else if (mode_select_pins != MODE_SCAN)
         scan_cnt <= 9'h000;
      else if (scan_cnt != 9'h1FF)
         scan_cnt <= scan_cnt + 9'h001;
   end
   sequence s_unsel;
      port_sel_n [*8];
   endsequence
   sequence s_din_steady;
      (busy_dout_oe && !port_pins_active && !init_err_oe && !config_done && $stable(serial_din)) [*6];
   endsequence
   sequence s_done_plain;
      (config_done && !port_retain) [*3];
   endsequence
   property p_sel;
      s_unsel |-> !$rose(cfg_byte_valid) || !port_pins_active;
   endproperty
   a_sel: assert property (p_sel) else $error("byte taken while deselected");
   property p_read;
      read_refused |-> $past(read_write_sel, 3) && $past(read_write_sel, 5) && !$past(port_sel_n, 3);
   endproperty
   a_read: assert property (p_read) else $error("read refusal without read");
   property p_busy;
      busy_dout_out && port_pins_active |-> cfg_byte_valid;
   endproperty
   a_busy: assert property (p_busy) else $error("busy with empty buffer");
   property p_ser;
      s_din_steady |-> busy_dout_out == serial_din;
   endproperty
   a_ser: assert property (p_ser) else $error("serial out not forwarded");
   property p_clr;
      clear_req |=> init_err_oe [*8];
   endproperty
   a_clr: assert property (p_clr) else $error("init line not low in clear");
   property p_rel;
      $fell(rst) |-> ##[198:204] !init_err_oe;
   endproperty
   a_rel: assert property (p_rel) else $error("init line not released");
   property p_err;
      cfg_error && port_pins_active && !config_done && !init_err_oe |-> ##[1:4] init_err_oe;
   endproperty
   a_err: assert property (p_err) else $error("error not flagged");
   property p_user;
      s_done_plain |-> !port_pins_active;
   endproperty
   a_user: assert property (p_user) else $error("port kept after done");
   property p_scan;
      scan_cnt > 9'h0D8 |-> !busy_dout_oe && !port_pins_active;
   endproperty
   a_scan: assert property (p_scan) else $error("pin used in scan mode");
endmodule
bind cpc_config_port cpc_config_port_properties cpc_config_port_properties_inst (.sys_clk, .rst, .clear_req,
   .port_retain, .port_sel_n, .read_write_sel, .mode_select_pins, .serial_din, .busy_dout_out, .busy_dout_oe,
   .init_err_oe, .cfg_byte_valid, .cfg_error, .config_done, .port_pins_active, .read_refused);

// [sim/cpc_host_model.sv]
`timescale 1ns/1ps
module cpc_host_model
   import cpc_pkg::*;
(
   // Clock
   input  wire logic         sys_clk,
   // Pins driven by the device
   input  wire logic         busy,
   input  wire logic         init_oe,
   // Outside party holding the init line low
   input  wire logic         hold_low,
   // Pins driven by the host
   output logic              sel_n,
   output logic              rw,
   output logic              strobe,
   output logic              init_line,
   output logic [BYTE_W-1:0] data
);
   // Pull-up: the line is low only while some party pulls it
   assign init_line = !(init_oe || hold_low);
   initial
   begin
      sel_n = 1'b1;
      rw = RW_WRITE;
      strobe = 1'b0;
      data = 8'hA5;
   end
   task automatic put(input logic [BYTE_W-1:0] d, input logic r, input logic s);
      int n;
      n = 0;
      while (busy && n < 400)
      begin
         @(posedge sys_clk);
         n++;
      end
      sel_n <= s;
      rw <= r;
      data <= d;
      repeat (3) @(posedge sys_clk);
      strobe <= 1'b1;
      repeat (4) @(posedge sys_clk);
      strobe <= 1'b0;
      repeat (4) @(posedge sys_clk);
      // Released pins show garbage, not the old byte; while busy the byte stays put
      if (!busy)
      begin
         sel_n <= 1'b1;
         data <= ~d;
      end
      // One idle edge so a following call never re-drives a pin in this time step
      @(posedge sys_clk);
   endtask
endmodule

// [sim/cpc_config_port_tb.sv]
`timescale 1ns/1ps
module cpc_config_port_tb;
   import cpc_pkg::*;
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; $display("mismatch %0t %h %h", $time, a, e); end end
   logic              sys_clk = 0, rst = 1, clear_req = 0, port_retain = 0, hold_low = 1;
   logic              port_sel_n, read_write_sel, xfer_strobe, busy_dout_out, busy_dout_oe;
   logic              init_err_in, init_err_out, init_err_oe, cfg_byte_valid, cfg_byte_ready = 0;
   logic              cfg_error = 0, cfg_finished = 0, config_done, port_pins_active, read_refused;
   logic [MODE_W-1:0] mode_select_pins = MODE_PAR_SLAVE;
   logic [BYTE_W-1:0] cfg_data_pins, cfg_byte_data;
   logic [BYTE_W-1:0] got[$];
   int                num_errors = 0, checked = 0, cycles = 0, refused = 0;
   always #2.5 sys_clk = ~sys_clk;
   cpc_config_port cpc_config_port_inst (.sys_clk, .rst, .clear_req, .mode_select_pins, .port_retain,
      .port_sel_n, .read_write_sel, .xfer_strobe, .cfg_data_pins, .serial_din(cfg_data_pins[0]),
      .busy_dout_out, .busy_dout_oe, .init_err_in, .init_err_out, .init_err_oe, .cfg_byte_valid,
      .cfg_byte_ready, .cfg_byte_data, .cfg_error, .cfg_finished, .config_done, .port_pins_active,
      .read_refused);
   cpc_host_model cpc_host_model_inst (.sys_clk, .busy(busy_dout_out & port_pins_active), .hold_low,
      .init_oe(init_err_oe), .sel_n(port_sel_n), .rw(read_write_sel), .strobe(xfer_strobe),
      .init_line(init_err_in), .data(cfg_data_pins));
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cfg_byte_valid === 1'b1 && cfg_byte_ready === 1'b1)
         got.push_back(cfg_byte_data);
      if (read_refused === 1'b1)
         refused++;
      if (cycles == 20000)
      begin
         num_errors++;
         stop_test();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic put(input logic [BYTE_W-1:0] d, input logic r, input logic s);
      cpc_host_model_inst.put(d, r, s);
   endtask
   task automatic restart(input logic [MODE_W-1:0] m);
      mode_select_pins <= m;
      clear_req <= 1'b1;
      tick(1);
      clear_req <= 1'b0;
      tick(215);
      `CHK(init_err_oe, 1'b0)
   endtask
   task automatic t_hold();
      `CHK(init_err_oe, 1'b1)
      tick(215);
      `CHK(init_err_oe, 1'b0)
      put(8'h3C, RW_WRITE, 1'b0);
      `CHK(cfg_byte_valid, 1'b0)
      hold_low <= 1'b0;
      tick(5);
      put(8'h5A, RW_WRITE, 1'b0);
      `CHK(cfg_byte_valid, 1'b1)
   endtask
   task automatic t_stall();
      logic [BYTE_W-1:0] want[3] = '{8'h5A, 8'h96, 8'hC3};
      put(8'h96, RW_WRITE, 1'b0);
      `CHK(busy_dout_out, 1'b1)
      fork
         put(8'hC3, RW_WRITE, 1'b0);
      join_none
      tick(20);
      `CHK(got.size(), 0)
      cfg_byte_ready <= 1'b1;
      tick(60);
      foreach (want[i]) `CHK(got[i], want[i])
      got.delete();
   endtask
   task automatic t_sel();
      put(8'h11, RW_WRITE, 1'b1);
      `CHK(got.size(), 0)
      put(8'h22, RW_READ, 1'b0);
      `CHK(got.size(), 0)
      `CHK(refused, 1)
   endtask
   task automatic t_err();
      cfg_error <= 1'b1;
      tick(1);
      cfg_error <= 1'b0;
      tick(4);
      `CHK(init_err_oe, 1'b1)
      `CHK(init_err_in, 1'b0)
      `CHK(init_err_out, 1'b0)
   endtask
   task automatic t_serial();
      logic [BYTE_W-1:0] b = 8'hB2;
      restart(MODE_SER_SLAVE);
      for (int i = 7; i >= 0; i--)
         put({7'h00, b[i]}, RW_WRITE, 1'b0);
      tick(3);
      `CHK(got[0], b)
      `CHK(busy_dout_oe, 1'b1)
      got.delete();
   endtask
   task automatic t_modes();
      logic [MODE_W-1:0] m[5] = '{MODE_SER_MASTER, MODE_SER_SLAVE, MODE_PAR_MASTER, MODE_PAR_SLAVE, MODE_SCAN};
      foreach (m[i])
      begin
         restart(m[i]);
         `CHK(port_pins_active, (m[i] == MODE_PAR_MASTER || m[i] == MODE_PAR_SLAVE))
      end
      tick(10);
      `CHK(busy_dout_oe, 1'b0)
   endtask
   task automatic t_done(input logic keep);
      port_retain <= keep;
      restart(MODE_PAR_SLAVE);
      cfg_finished <= 1'b1;
      tick(1);
      cfg_finished <= 1'b0;
      tick(5);
      `CHK(config_done, 1'b1)
      `CHK(port_pins_active, keep)
   endtask
   task automatic stop_test();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      tick(6);
      rst <= 1'b0;
      tick(1);
      t_hold();
      t_stall();
      t_sel();
      t_err();
      t_serial();
      t_modes();
      t_done(1'b1);
      t_done(1'b0);
      stop_test();
   end
endmodule
